//--- hdl/i2ccp_params.svh
// Purpose: Constants of the two-wire control port: address, sizes, encodings.
// Assumes: Included by the package and by the design modules.
// Notes: Definitions only.
`ifndef I2CCP_PARAMS_SVH
`define I2CCP_PARAMS_SVH

// Seven-bit slave address of the port.
`define I2CCP_SLAVE_ADDR 7'h36
// Largest register, in bytes, that one subaddress can hold.
`define I2CCP_MAX_BYTES 20
// Bytes in one data word.
`define I2CCP_WORD_BYTES 5'h04
// Bits in one data word.
`define I2CCP_WORD_BITS 6'h20
// Level that the synchronisers take at reset: an idle bus is high.
`define I2CCP_IDLE_LVL 1'b1
// One-hot codes of the bit-level states.
`define I2CCP_ST_IDLE 5'h01
`define I2CCP_ST_RX 5'h02
`define I2CCP_ST_ACK 5'h04
`define I2CCP_ST_TX 5'h08
`define I2CCP_ST_MACK 5'h10
// One-hot codes of the byte phases of a transfer.
`define I2CCP_PH_ADDR 3'h1
`define I2CCP_PH_SUB 3'h2
`define I2CCP_PH_DATA 3'h4

`endif

//--- hdl/i2ccp_pkg.sv
// Purpose: Types shared by the control port modules.
// Assumes: i2ccp_params.svh holds the numbers.
// Notes: State of each module is one packed struct.
`include "i2ccp_params.svh"

package i2ccp_pkg;

  typedef logic [7:0] i2ccp_byte_t;
  typedef logic [4:0] i2ccp_cnt_t;
  typedef logic [2:0] i2ccp_widx_t;
  typedef logic [31:0] i2ccp_word_t;
  typedef logic [5:0] i2ccp_bits_t;
  typedef logic [`I2CCP_MAX_BYTES*8-1:0] i2ccp_wbuf_t;

  typedef enum logic [4:0] {
    ST_IDLE = `I2CCP_ST_IDLE,
    ST_RX = `I2CCP_ST_RX,
    ST_ACK = `I2CCP_ST_ACK,
    ST_TX = `I2CCP_ST_TX,
    ST_MACK = `I2CCP_ST_MACK
  } i2ccp_st_t;

  typedef enum logic [2:0] {
    PH_ADDR = `I2CCP_PH_ADDR,
    PH_SUB = `I2CCP_PH_SUB,
    PH_DATA = `I2CCP_PH_DATA
  } i2ccp_ph_t;

  // Synchroniser state: two flops per line, then one delayed copy.
  typedef struct packed {
    logic [1:0] scl_ff;
    logic [1:0] sda_ff;
    logic scl_d;
    logic sda_d;
  } i2ccp_sync_t;

  // Protocol engine state.
  typedef struct packed {
    i2ccp_st_t st;
    i2ccp_ph_t phase;
    logic rw;
    logic [3:0] bitcnt;
    i2ccp_byte_t shreg;
    i2ccp_byte_t tx;
    logic drv;
    logic nack;
    i2ccp_byte_t sub;
    i2ccp_cnt_t cnt;
    i2ccp_wbuf_t bufr;
    i2ccp_byte_t split_sub;
    i2ccp_widx_t split_idx;
    logic wr_stb;
    i2ccp_byte_t wr_addr;
    i2ccp_widx_t wr_word;
    i2ccp_cnt_t wr_len;
    i2ccp_wbuf_t wr_data;
  } i2ccp_state_t;

endpackage

//--- hdl/i2ccp_sync.sv
// Purpose: Bring the bus lines into the clock domain and find their events.
// Assumes: scl_in and sda_in are asynchronous pins.
// Notes: Events are one-cycle pulses, about two cycles after the pin moves.
`timescale 1ns/1ps
`default_nettype none
`include "i2ccp_params.svh"

module i2ccp_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_lvl,
  output logic sda_lvl,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  import i2ccp_pkg::*;

  i2ccp_sync_t sync_reg;
  i2ccp_sync_t sync_next;

  // The first flop of each pair feeds only the second one.
  always_comb
  begin
    sync_next = sync_reg;
    sync_next.scl_ff = {sync_reg.scl_ff[0], scl_in};
    sync_next.sda_ff = {sync_reg.sda_ff[0], sda_in};
    sync_next.scl_d = sync_reg.scl_ff[1];
    sync_next.sda_d = sync_reg.sda_ff[1];
  end

  // Reset to the idle-high level, so release never looks like a start.
  // Both flops of each pair are named in full: a one-bit fill value would
  // only set the low flop and fake a clock edge just after reset.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync_reg <= '{
        scl_ff: {2{`I2CCP_IDLE_LVL}},
        sda_ff: {2{`I2CCP_IDLE_LVL}},
        scl_d: `I2CCP_IDLE_LVL,
        sda_d: `I2CCP_IDLE_LVL
      };
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  // Both lines pass equal delay, so their relative order is kept.
  assign scl_lvl = sync_reg.scl_ff[1];
  assign sda_lvl = sync_reg.sda_ff[1];
  assign scl_rise = sync_reg.scl_ff[1] & ~sync_reg.scl_d;
  assign scl_fall = ~sync_reg.scl_ff[1] & sync_reg.scl_d;
  assign start_det = sync_reg.scl_ff[1] & sync_reg.scl_d & sync_reg.sda_d & ~sync_reg.sda_ff[1];
  assign stop_det = sync_reg.scl_ff[1] & sync_reg.scl_d & ~sync_reg.sda_d & sync_reg.sda_ff[1];

endmodule

`default_nettype wire

//--- hdl/i2ccp_port.sv
// Purpose: Slave-only two-wire control port that feeds the register file.
// Assumes: The register file answers reg_len, rd_data and rd_bits
//   combinationally from reg_addr and rd_word.
// Notes: The clock is the local oscillator, never the audio master clock.
// Notes on behaviour
// - Answer only slave address 0x36; the eighth bit selects direction.
// - Work at 100 and 400 kHz; never stretch the clock or wait.
// - Depend only on bus signals, not on the audio master clock.
// - Slave only; never start transfers or arbitrate.
// - Bytes are eight bits, MSB first, each followed by an acknowledge.
// - Falling data with clock high is start; rising data is stop.
// - Change the data line only while the clock is low.
// - Acknowledge by holding data low for the whole acknowledge period.
// - Accept any number of bytes between start and stop.
// - Small registers take single bytes; processing registers take 4-byte words.
// - Keep sending bytes from the subaddress while the master acknowledges.
// - Unused bits of a narrow register read back as zero.
// - Count bytes per subaddress; drop incomplete data at stop or start.
// - A mixer coefficient commits only after one whole 32-bit word.
// - Sequential writes advance through consecutive subaddresses.
// - Drop only the incomplete final subaddress; keep earlier complete ones.
// - Split mode lets large registers arrive in 4-byte steps across transfers.
// - Write is start, address with 0, subaddress, data, acknowledges, stop.
// - Acknowledge every received data byte.
// - Read is subaddress write, repeated start, address with 1, data, nack.
`timescale 1ns/1ps
`default_nettype none
`include "i2ccp_params.svh"

module i2ccp_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic split_mode,
  output i2ccp_pkg::i2ccp_byte_t reg_addr,
  input wire i2ccp_pkg::i2ccp_cnt_t reg_len,
  output i2ccp_pkg::i2ccp_widx_t rd_word,
  input wire i2ccp_pkg::i2ccp_word_t rd_data,
  input wire i2ccp_pkg::i2ccp_bits_t rd_bits,
  output logic wr_stb,
  output i2ccp_pkg::i2ccp_byte_t wr_addr,
  output i2ccp_pkg::i2ccp_widx_t wr_word,
  output i2ccp_pkg::i2ccp_cnt_t wr_len,
  output i2ccp_pkg::i2ccp_wbuf_t wr_data
);
  import i2ccp_pkg::*;

  localparam int BUF_BITS = `I2CCP_MAX_BYTES * 8;
  // Reset state: idle, line released, no pending data.
  localparam i2ccp_state_t RESET_STATE = '{
    st: ST_IDLE,
    phase: PH_ADDR,
    default: '0
  };

  i2ccp_state_t state_reg;
  i2ccp_state_t state_next;

  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Only the bus lines and the local clock drive this port.
  i2ccp_sync u_sync (
    .clock(clock),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_lvl(scl_lvl),
    .sda_lvl(sda_lvl),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // Zero the bit positions that the addressed register does not hold.
  function automatic i2ccp_word_t mask_word(i2ccp_word_t data, i2ccp_bits_t bits);
    i2ccp_word_t keep;
    keep = 32'hFFFFFFFF;
    if (bits < `I2CCP_WORD_BITS)
    begin
      keep = 32'((33'h1 << bits) - 33'h1);
    end
    return data & keep;
  endfunction

  // Bytes that one read step of this register spans: a narrow register
  // sends its own length, a wide one a word at a time.
  function automatic i2ccp_cnt_t word_span(i2ccp_cnt_t len);
    i2ccp_cnt_t span;
    span = `I2CCP_WORD_BYTES;
    if (len == 5'h00)
    begin
      span = 5'h01;
    end
    else if (len < `I2CCP_WORD_BYTES)
    begin
      span = len;
    end
    return span;
  endfunction

  // Fetch the next read byte and step the read pointer. The pointer moves
  // at load time, so the register file has a whole byte time to settle.
  function automatic i2ccp_state_t load_byte(
    i2ccp_state_t c,
    i2ccp_cnt_t len,
    i2ccp_word_t data,
    i2ccp_bits_t bits
  );
    i2ccp_state_t r;
    i2ccp_word_t w;
    i2ccp_cnt_t span;
    i2ccp_cnt_t pos;
    i2ccp_cnt_t total;
    r = c;
    w = mask_word(data, bits);
    span = word_span(len);
    total = (len == 5'h00) ? 5'h01 : len;
    // Within a word the most significant byte goes first.
    if (span < `I2CCP_WORD_BYTES)
    begin
      pos = 5'(span - 5'h01 - c.cnt);
    end
    else
    begin
      pos = 5'(5'h03 - {3'h0, c.cnt[1:0]});
    end
    r.tx = 8'(w >> {pos[1:0], 3'b000});
    r.drv = ~r.tx[7];
    r.bitcnt = 4'h0;
    r.st = ST_TX;
    // When the register is used up, move on to the next subaddress.
    if (5'(c.cnt + 5'h01) >= total)
    begin
      r.sub = 8'(c.sub + 8'h01);
      r.cnt = 5'h00;
    end
    else
    begin
      r.cnt = 5'(c.cnt + 5'h01);
    end
    return r;
  endfunction

  // Take one data byte: collect it, and commit when the subaddress has its
  // full set. In split mode a wide register commits word by word.
  function automatic i2ccp_state_t take_byte(
    i2ccp_state_t c,
    i2ccp_cnt_t len,
    logic split
  );
    i2ccp_state_t r;
    i2ccp_cnt_t need;
    logic split_on;
    i2ccp_cnt_t done_bytes;
    r = c;
    split_on = split && (len > `I2CCP_WORD_BYTES);
    need = split_on ? `I2CCP_WORD_BYTES : len;
    done_bytes = 5'({3'(c.split_idx + 3'h1), 2'b00});
    // Byte count against the size this subaddress needs.
    if (5'(c.cnt + 5'h01) >= need)
    begin
      r.wr_data = {c.bufr[BUF_BITS-9:0], c.shreg};
      r.bufr = '0;
      r.wr_stb = 1'b1;
      r.wr_addr = c.sub;
      r.wr_len = need;
      r.cnt = 5'h00;
      if (split_on)
      begin
        // One word of a large register; progress survives the stop.
        r.wr_word = c.split_idx;
        if (done_bytes >= len)
        begin
          r.sub = 8'(c.sub + 8'h01);
          r.split_idx = 3'h0;
          r.split_sub = 8'(c.sub + 8'h01);
        end
        else
        begin
          r.split_idx = 3'(c.split_idx + 3'h1);
        end
      end
      else
      begin
        // Complete set taken; the next bytes go to the next subaddress.
        r.wr_word = 3'h0;
        r.sub = 8'(c.sub + 8'h01);
        r.split_idx = 3'h0;
        r.split_sub = 8'(c.sub + 8'h01);
      end
    end
    else
    begin
      r.bufr = {c.bufr[BUF_BITS-9:0], c.shreg};
      r.cnt = 5'(c.cnt + 5'h01);
    end
    return r;
  endfunction

  // Protocol engine. Start and stop override any bit state, since the
  // master may end a transfer at any point.
  always_comb
  begin
    state_next = state_reg;
    state_next.wr_stb = 1'b0;
    if (start_det)
    begin
      // A new start drops any incomplete set; commits already made stay.
      state_next.st = ST_RX;
      state_next.phase = PH_ADDR;
      state_next.bitcnt = 4'h0;
      state_next.cnt = 5'h00;
      state_next.bufr = '0;
      state_next.drv = 1'b0;
    end
    else if (stop_det)
    begin
      // Stop ends the transfer; an incomplete set is discarded.
      state_next.st = ST_IDLE;
      state_next.cnt = 5'h00;
      state_next.bufr = '0;
      state_next.drv = 1'b0;
    end
    else
    begin
      unique case (state_reg.st)
        ST_IDLE:
        begin
          state_next.drv = 1'b0;
        end
        ST_RX:
        begin
          // Sample on the rising clock, MSB first.
          if (scl_rise)
          begin
            state_next.shreg = {state_reg.shreg[6:0], sda_lvl};
            state_next.bitcnt = 4'(state_reg.bitcnt + 4'h1);
          end
          // Act on the falling edge after the eighth bit, so the line
          // only moves while the clock is low.
          else if (scl_fall && state_reg.bitcnt == 4'h8)
          begin
            state_next.bitcnt = 4'h0;
            unique case (state_reg.phase)
              PH_ADDR:
              begin
                if (state_reg.shreg[7:1] == `I2CCP_SLAVE_ADDR)
                begin
                  state_next.rw = state_reg.shreg[0];
                  state_next.drv = 1'b1;
                  state_next.st = ST_ACK;
                end
                else
                begin
                  // Not ours: stay released until the next start.
                  state_next.st = ST_IDLE;
                end
              end
              PH_SUB:
              begin
                state_next.sub = state_reg.shreg;
                state_next.cnt = 5'h00;
                if (state_reg.shreg != state_reg.split_sub)
                begin
                  state_next.split_idx = 3'h0;
                end
                state_next.split_sub = state_reg.shreg;
                state_next.drv = 1'b1;
                state_next.st = ST_ACK;
              end
              PH_DATA:
              begin
                // No length limit: every data byte is taken and acknowledged.
                state_next = take_byte(state_reg, reg_len, split_mode);
                state_next.wr_stb = (5'(state_reg.cnt + 5'h01) >=
                  ((split_mode && reg_len > `I2CCP_WORD_BYTES) ? `I2CCP_WORD_BYTES : reg_len));
                state_next.bitcnt = 4'h0;
                state_next.drv = 1'b1;
                state_next.st = ST_ACK;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          // Held low from one falling edge to the next: the whole period.
          if (scl_fall)
          begin
            state_next.drv = 1'b0;
            if (state_reg.phase == PH_ADDR && state_reg.rw)
            begin
              // Read direction: first byte from the current subaddress.
              state_next = load_byte(state_reg, reg_len, rd_data, rd_bits);
            end
            else
            begin
              state_next.st = ST_RX;
              state_next.bitcnt = 4'h0;
              state_next.phase = (state_reg.phase == PH_ADDR) ? PH_SUB : PH_DATA;
            end
          end
        end
        ST_TX:
        begin
          // Next bit goes out on the falling edge, never while high.
          if (scl_fall)
          begin
            if (state_reg.bitcnt == 4'h7)
            begin
              state_next.drv = 1'b0;
              state_next.st = ST_MACK;
            end
            else
            begin
              state_next.tx = {state_reg.tx[6:0], 1'b0};
              state_next.drv = ~state_reg.tx[6];
              state_next.bitcnt = 4'(state_reg.bitcnt + 4'h1);
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            state_next.nack = sda_lvl;
          end
          else if (scl_fall)
          begin
            // Acknowledged: keep sending; not acknowledged: let go.
            if (!state_reg.nack)
            begin
              state_next = load_byte(state_reg, reg_len, rd_data, rd_bits);
            end
            else
            begin
              state_next.st = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // One register for the whole engine.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= RESET_STATE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Open-drain data line: only ever pulled low. The clock line has no
  // driver at all, so the port cannot stretch it or contend for the bus,
  // and timing comes from the master alone.
  assign sda_out = 1'b0;
  assign sda_oe = state_reg.drv;

  // Register-file side.
  assign reg_addr = state_reg.sub;
  assign rd_word = state_reg.cnt[4:2];
  assign wr_stb = state_reg.wr_stb;
  assign wr_addr = state_reg.wr_addr;
  assign wr_word = state_reg.wr_word;
  assign wr_len = state_reg.wr_len;
  assign wr_data = state_reg.wr_data;

endmodule

`default_nettype wire

//--- verif/i2ccp_port_chk.sv
// Purpose: Concurrent checks on the ports of the two-wire control port.
// Assumes: Pin events reach the port logic within a few clock cycles.
// Notes: Bound to every instance of the port module.
`timescale 1ns/1ps
`default_nettype none

module i2ccp_port_chk
  import i2ccp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire i2ccp_pkg::i2ccp_byte_t reg_addr,
  input wire logic wr_stb,
  input wire i2ccp_pkg::i2ccp_byte_t wr_addr,
  input wire i2ccp_pkg::i2ccp_cnt_t wr_len
);
  // All checks share the system clock and its reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // The pin is open drain, so only a low level may ever be offered.
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  reset_idle_a: assert property ($fell(rst) |-> !sda_oe && !wr_stb && reg_addr == 8'h00)
    else $error("port not idle after reset");
  // The data line may move only while the bus clock is low.
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data line moved with clock high");
  // A late answer would amount to stretching, so it must follow a recent clock fall.
  resp_time_a: assert property ($changed(sda_oe) |-> $past(scl_in, 3) || $past(scl_in, 4) ||
    $past(scl_in, 5) || $past(scl_in, 6))
    else $error("data line answer not tied to clock fall");
  stb_gap_a: assert property (wr_stb |=> !wr_stb [*8])
    else $error("commit pulses too close");
  stb_ack_a: assert property (wr_stb |-> sda_oe)
    else $error("commit without acknowledge");
  stb_low_a: assert property (wr_stb |-> !scl_in)
    else $error("commit with clock high");
  len_range_a: assert property (wr_stb |-> wr_len inside {[5'h01:5'h14]})
    else $error("commit length out of range");
  wr_hold_a: assert property (!wr_stb |-> $stable(wr_addr) && $stable(wr_len))
    else $error("commit fields moved without a pulse");
endmodule

bind i2ccp_port i2ccp_port_chk chk (
  .clock(clock),
  .rst(rst),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .reg_addr(reg_addr),
  .wr_stb(wr_stb),
  .wr_addr(wr_addr),
  .wr_len(wr_len)
);

`default_nettype wire

//--- verif/i2ccp_master.sv
// Purpose: Behavioural system controller that masters the two-wire bus.
// Assumes: Lines are pulled up; the model releases a line by driving one.
// Notes: Bus clock period 125 ns, running only inside frames.
`timescale 1ns/1ps
`default_nettype none

module i2ccp_master (
  output logic scl,
  output logic sda,
  input wire logic sda_w
);
  localparam realtime Q = 31.25;

  // Idle bus: both lines released.
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda = 1'b1;
    #(Q);
    scl = 1'b1;
    #(Q);
    sda = 1'b0;
    #(Q);
    scl = 1'b0;
    #(Q);
  endtask

  // Stop: data rises while the clock is high, then the clock stands still.
  task automatic stop();
    sda = 1'b0;
    #(Q);
    scl = 1'b1;
    #(Q);
    sda = 1'b1;
    #(2 * Q);
  endtask

  // One bit: data set in the low half, sampled mid-way through the high half.
  task automatic bit_io(input logic b, output logic r);
    sda = b;
    #(Q);
    scl = 1'b1;
    #(Q);
    r = sda_w;
    #(Q);
    scl = 1'b0;
    #(Q);
  endtask

  // Byte out MSB first, then the receiver's acknowledge is read.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in MSB first, then acknowledge or, for the last byte, not-acknowledge.
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule

`default_nettype wire

//--- verif/i2c_control_slave_port_test.sv
// Purpose: Self-checking bench for the two-wire control port.
// Assumes: Stand-in register file: 1 byte below 0x20, 4 from 0x20, 20 from 0x30.
// Notes: Commits are logged and judged in order by each scenario.
`timescale 1ns/1ps
`default_nettype none

module i2c_control_slave_port_test;
  import i2ccp_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic split_mode = 1'b0;
  logic scl, m_sda, sda_out, sda_oe, wr_stb;
  wire logic sda_w;
  i2ccp_byte_t reg_addr, wr_addr;
  i2ccp_cnt_t reg_len, wr_len;
  i2ccp_widx_t rd_word, wr_word;
  i2ccp_word_t rd_data;
  i2ccp_bits_t rd_bits;
  i2ccp_wbuf_t wr_data;
  logic [175:0] q[$];
  int fails = 0;
  int checked = 0;

  // Wired-AND of the pulled-up data line.
  assign sda_w = m_sda & (sda_oe ? sda_out : 1'b1);

  i2ccp_master m (.scl(scl), .sda(m_sda), .sda_w(sda_w));

  i2ccp_port dut (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .split_mode(split_mode), .reg_addr(reg_addr), .reg_len(reg_len),
    .rd_word(rd_word), .rd_data(rd_data), .rd_bits(rd_bits), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_word(wr_word), .wr_len(wr_len), .wr_data(wr_data));

  // Register file stand-in; the top byte of each word is junk that narrow reads must hide.
  always_comb
  begin
    reg_len = reg_addr >= 8'h30 ? 5'h14 : (reg_addr >= 8'h20 ? 5'h04 : 5'h01);
    rd_bits = reg_addr == 8'h21 ? 6'h18 : (reg_addr >= 8'h20 ? 6'h20 : 6'h08);
    rd_data = {reg_addr, 5'h00, rd_word, 8'hA5, reg_addr};
  end

  initial
  begin
    forever #5 clock = ~clock;
  end

  // Every commit is logged so scenarios can judge them after the bus settles.
  always @(posedge clock)
    if (wr_stb === 1'b1)
      q.push_back({wr_addr, wr_word, wr_len, wr_data});

  task automatic chk(input string name, input logic [175:0] e, input logic [175:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic open_wr(input i2ccp_byte_t s);
    logic a;
    q.delete();
    m.start();
    m.wbyte(8'h6C, a);
    chk("addr ack", 1'b1, a);
    m.wbyte(s, a);
    chk("sub ack", 1'b1, a);
  endtask

  task automatic send(input int n, input i2ccp_byte_t f);
    logic a;
    for (int i = 0; i < n; i++)
    begin
      m.wbyte(f + 8'(i), a);
      chk("data ack", 1'b1, a);
    end
  endtask

  // Expected set is right-aligned: the last byte lands in the low bits.
  task automatic expect_set(input i2ccp_byte_t s, input i2ccp_widx_t w, input int n,
    input i2ccp_byte_t f);
    logic [175:0] e;
    e = {s, w, 5'(n), 160'h0};
    for (int i = 0; i < n; i++)
      e[159:0] = {e[151:0], f + 8'(i)};
    chk("commit", e, q.size() > 0 ? q.pop_front() : 176'h0);
  endtask

  task automatic rd(input i2ccp_byte_t s, input int n, input logic [31:0] e);
    logic a;
    i2ccp_byte_t d;
    open_wr(s);
    m.start();
    m.wbyte(8'h6D, a);
    chk("read ack", 1'b1, a);
    for (int i = n - 1; i >= 0; i--)
    begin
      m.rbyte(i == 0, d);
      chk("read byte", e[8*i +: 8], d);
    end
    m.stop();
  endtask

  task automatic t_foreign();
    logic a;
    q.delete();
    m.start();
    m.wbyte(8'h6E, a);
    chk("foreign ack", 1'b0, a);
    m.wbyte(8'h02, a);
    chk("ignored ack", 1'b0, a);
    m.stop();
    chk("commits", 0, q.size());
  endtask

  task automatic t_seq();
    open_wr(8'h02);
    send(3, 8'h11);
    m.stop();
    for (int i = 0; i < 3; i++)
      expect_set(8'h02 + 8'(i), 3'h0, 1, 8'h11 + 8'(i));
    chk("commits", 0, q.size());
  endtask

  task automatic t_mixer();
    open_wr(8'h20);
    send(7, 8'h40);
    m.stop();
    expect_set(8'h20, 3'h0, 4, 8'h40);
    chk("commits", 0, q.size());
  endtask

  task automatic t_biquad();
    open_wr(8'h30);
    send(12, 8'h60);
    m.start();
    m.stop();
    chk("commits", 0, q.size());
    open_wr(8'h30);
    send(20, 8'h80);
    m.stop();
    expect_set(8'h30, 3'h0, 20, 8'h80);
  endtask

  task automatic t_split();
    @(posedge clock);
    #1 split_mode = 1'b1;
    open_wr(8'h30);
    send(4, 8'hA0);
    m.stop();
    expect_set(8'h30, 3'h0, 4, 8'hA0);
    open_wr(8'h30);
    send(8, 8'hB0);
    m.stop();
    expect_set(8'h30, 3'h1, 4, 8'hB0);
    expect_set(8'h30, 3'h2, 4, 8'hB4);
    @(posedge clock);
    #1 split_mode = 1'b0;
  endtask

  task automatic t_read();
    rd(8'h0E, 3, 32'h000E0F10);
    rd(8'h21, 4, 32'h0000A521);
  endtask

  initial
  begin
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    t_foreign();
    t_seq();
    t_mixer();
    t_biquad();
    t_split();
    t_read();
    give_verdict();
  end

  // Watchdog: the run needs well under half a millisecond of bus time.
  initial
  begin
    #900000;
    fails++;
    give_verdict();
  end
endmodule

`default_nettype wire
